// file: design/out_stage_pkg.sv
package out_stage_pkg;

  // ----------------------------------------------------------------
  // register map (word index; byte address is index times four)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS_P0    = 8'h03;  // page 0 reg 3
  localparam logic [7:0] IDX_SOFTSTEP_P0  = 8'h3f;  // page 0 reg 63
  localparam logic [7:0] IDX_HP_DRV_P1    = 8'h1f;  // page 1 reg 31
  localparam logic [7:0] IDX_SPK_DRV_P1   = 8'h20;  // page 1 reg 32
  localparam logic [7:0] IDX_SPK_VOL_L_P1 = 8'h26;  // page 1 reg 38
  localparam logic [7:0] IDX_SPK_VOL_R_P1 = 8'h27;  // page 1 reg 39
  localparam logic [7:0] IDX_HP_GAIN_L_P1 = 8'h28;  // page 1 reg 40
  localparam logic [7:0] IDX_HP_GAIN_R_P1 = 8'h29;  // page 1 reg 41
  localparam logic [7:0] IDX_SPK_GAIN_P1  = 8'h2a;  // page 1 reg 42
  localparam logic [7:0] IDX_HP_MODE_P1   = 8'h2c;  // page 1 reg 44
  localparam logic [7:0] IDX_CONTROL      = 8'h80;  // software reset, page 1 window
  localparam int         PAGE1_BASE       = 256;    // page 1 indices start here

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int HP_L_PWR_BIT  = 7;
  localparam int HP_R_PWR_BIT  = 6;
  localparam int HP_CM_LSB     = 3;
  localparam int HP_SHDN_BIT   = 1;
  localparam int HP_SHORT_BIT  = 0;
  localparam int SPK_PWR_BIT   = 7;
  localparam int SPK_SHORT_BIT = 0;
  localparam int OTP_FLAG_BIT  = 1;
  localparam int ROUTE_BIT     = 7;
  localparam int MUTE_BIT      = 2;
  localparam int HP_GAIN_LSB   = 3;
  localparam int SPK_GAIN_LSB  = 3;
  localparam int HP_MODE_LSB   = 1;
  localparam logic [1:0] HP_MODE_LINEOUT = 2'h3;
  localparam logic [6:0] VOL_MUTE_CODE   = 7'h7f;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_VOL         = 8'h7f;  // routed off, muted
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam int         CLK_MHZ         = 200;
  localparam int         SOFTSTEP_US     = 1;      // base step time
  localparam int         STEP_CYCLES     = SOFTSTEP_US * CLK_MHZ;
  localparam int         SOFTSTART_US    = 10;
  localparam int         SOFTSTART_CYC   = SOFTSTART_US * CLK_MHZ;

  typedef struct packed {
    logic       route;
    logic [6:0] level;
    logic       mute;
  } vol_out_t;

  typedef struct packed {
    logic       power;
    logic [3:0] gain;
    logic       mute;
  } drv_out_t;

endpackage

// file: design/vol_softstep.sv
`timescale 1ns/1ps
module vol_softstep
  import out_stage_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [1:0] step_sel_i,
  input  wire logic [7:0] target_i,
  output vol_out_t        vol_o
);

  logic [15:0] tick_q;
  logic [15:0] tick_lim;
  logic [6:0]  level_q;
  logic        tick;

  // step period doubles per select code; code 3 steps one code every cycle
  assign tick_lim = 16'(STEP_CYCLES) << step_sel_i;
  assign tick     = (tick_q >= tick_lim - 16'h0001) || (step_sel_i == 2'h3);

  // ----------------------------------------------------------------
  // step timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_q <= 16'h0000;
    end else if (ce_i) begin
      tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
    end
  end

  // walk the level one half-decibel code per tick, avoiding zipper noise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_q <= VOL_MUTE_CODE;
    end else if (ce_i && tick) begin
      if (level_q < target_i[6:0]) begin
        level_q <= level_q + 7'h01;
      end else if (level_q > target_i[6:0]) begin
        level_q <= level_q - 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vol_o <= '{route: 1'b0, level: VOL_MUTE_CODE, mute: 1'b1};
    end else if (ce_i) begin
      vol_o.route <= target_i[ROUTE_BIT];
      vol_o.level <= level_q;
      vol_o.mute  <= !target_i[ROUTE_BIT] && (target_i[6:0] == VOL_MUTE_CODE);
    end
  end

  a_level_moves: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tick && level_q != target_i[6:0] |=> level_q != $past(level_q))
    else $error("volume level did not step");
  a_mute_code: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !target_i[7] && target_i[6:0] == 7'h7f |=> vol_o.mute)
    else $error("mute code not honoured");

endmodule // vol_softstep

// file: design/output_stage_power_protect_ctrl.sv
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - speaker volume steps by half-decibel codes toward target through soft stepping
// - left and right speaker volume are seven-bit fields in page-one 38 and 39
// - left speaker volume bit 7 routes volume output to mono speaker amplifier
// - page-zero 63 bits 1:0 choose soft-step time
// - page-one 44 bits 2:1 equal 11 selects line-output drive mode
// - page-one 31 bits 4:3 select output common-mode level
// - page-one 31 bits 7 and 6 power left and right headphone drivers
// - page-one 40 and 41 hold headphone gain bits 6:3 and mute bit 2
// - headphone short limits current when bit 1 is zero, else shuts down
// - headphone short on either side sets read-only bit 0 of page-one 31
// - in shutdown mode a short clears the affected headphone power bit
// - shut stage stays off until re-enable or master reset restoring defaults
// - rewriting a headphone power bit restarts only that stage; faults repeat shutdown
// - page-one 32 bit 7 powers speaker; 42 holds gain 4:3 and mute 2
// - speaker overcurrent always shuts down and sets bit 0 of page-one 32
// - rewriting speaker power bit restarts only speaker stage; faults repeat shutdown
// - over-temperature stops speaker switching until cool; flag at page-zero 3 bit 1
// - each of three stages soft-starts independently on power change
// - volume stage muted when route bit is zero and volume code is 127
module output_stage_power_protect_ctrl
  import out_stage_pkg::*;
#(
  parameter int SOFTSTART_CYCLES = SOFTSTART_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // analog fault detectors
  input  wire logic        hp_l_short_i,
  input  wire logic        hp_r_short_i,
  input  wire logic        spk_short_i,
  input  wire logic        over_temp_i,
  // analog controls
  output vol_out_t         spk_vol_l_o,
  output vol_out_t         spk_vol_r_o,
  output drv_out_t         left_headphone_driver_o,
  output drv_out_t         right_headphone_driver_o,
  output drv_out_t         speaker_driver_o,
  output logic             hp_current_limit_o,
  output logic             hp_lineout_mode_o,
  output logic [1:0]       hp_common_mode_o,
  output logic             speaker_switch_en_o,
  output logic [2:0]       stage_ramping_o
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] softstep_q, hp_drv_q, spk_drv_q, vol_l_q, vol_r_q;
  logic [7:0] hp_gain_l_q, hp_gain_r_q, spk_gain_q, hp_mode_q;
  logic       hp_short_q, spk_short_q, otp_q;
  logic       soft_rst_q;
  logic       page1_q;
  logic       srst;
  logic       wr_stb, rd_stb;
  logic [8:0] idx;
  logic       wr_hp, wr_spk;
  logic       hp_l_trip, hp_r_trip, spk_trip;
  logic [2:0] pwr_now;
  logic [2:0] pwr_prev_q;
  logic [2:0] ramp_busy;
  logic [31:0] rd_d;
  vol_out_t   vol_l_s, vol_r_s;

  assign srst   = rst_i || soft_rst_q;
  // writes land on the edge where the master sees ack, while it still holds the request
  assign wr_stb = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  assign rd_stb = cyc_i && stb_i && !we_i && !ack_o;
  assign idx    = {page1_q && (adr_i[9:2] != IDX_CONTROL), adr_i[9:2]};
  assign wr_hp  = wr_stb && (idx == 9'(PAGE1_BASE) + 9'(IDX_HP_DRV_P1));
  assign wr_spk = wr_stb && (idx == 9'(PAGE1_BASE) + 9'(IDX_SPK_DRV_P1));

  // fault trips: headphone only in shutdown mode, speaker always
  assign hp_l_trip = hp_drv_q[HP_SHDN_BIT] && hp_l_short_i;
  assign hp_r_trip = hp_drv_q[HP_SHDN_BIT] && hp_r_short_i;
  assign spk_trip  = spk_short_i;

  // ----------------------------------------------------------------
  // bus handshake, one registered ack per request, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else if (ce_i) begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // control register: bit 0 software reset pulse, bit 1 page select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_rst_q <= 1'b0;
      page1_q    <= 1'b0;
    end else if (ce_i) begin
      soft_rst_q <= wr_stb && (adr_i[9:2] == IDX_CONTROL) && dat_i[0];
      if (wr_stb && adr_i[9:2] == IDX_CONTROL) begin
        page1_q <= dat_i[1];
      end
    end
  end

  // plain configuration registers, all returned to defaults by master reset
  always_ff @(posedge clk_i) begin
    if (srst) begin
      softstep_q  <= RST_ZERO;
      vol_l_q     <= RST_VOL;
      vol_r_q     <= RST_VOL;
      hp_gain_l_q <= RST_ZERO;
      hp_gain_r_q <= RST_ZERO;
      spk_gain_q  <= RST_ZERO;
      hp_mode_q   <= RST_ZERO;
    end else if (ce_i && wr_stb) begin
      case (idx)
        {1'b0, IDX_SOFTSTEP_P0}:  softstep_q  <= dat_i[7:0];
        {1'b1, IDX_SPK_VOL_L_P1}: vol_l_q     <= dat_i[7:0];
        {1'b1, IDX_SPK_VOL_R_P1}: vol_r_q     <= dat_i[7:0];
        {1'b1, IDX_HP_GAIN_L_P1}: hp_gain_l_q <= dat_i[7:0];
        {1'b1, IDX_HP_GAIN_R_P1}: hp_gain_r_q <= dat_i[7:0];
        {1'b1, IDX_SPK_GAIN_P1}:  spk_gain_q  <= dat_i[7:0];
        {1'b1, IDX_HP_MODE_P1}:   hp_mode_q   <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // headphone power/config; a trip beats a same-cycle write of the power bit
  always_ff @(posedge clk_i) begin
    if (srst) begin
      hp_drv_q <= RST_ZERO;
    end else if (ce_i) begin
      if (wr_hp) begin
        hp_drv_q[7:1] <= dat_i[7:1];
      end
      if (hp_l_trip) begin
        hp_drv_q[HP_L_PWR_BIT] <= 1'b0;
      end
      if (hp_r_trip) begin
        hp_drv_q[HP_R_PWR_BIT] <= 1'b0;
      end
    end
  end

  // speaker power, cleared by any overcurrent
  always_ff @(posedge clk_i) begin
    if (srst) begin
      spk_drv_q <= RST_ZERO;
    end else if (ce_i) begin
      if (wr_spk) begin
        spk_drv_q[7:1] <= dat_i[7:1];
      end
      if (spk_trip) begin
        spk_drv_q[SPK_PWR_BIT] <= 1'b0;
      end
    end
  end

  // status flags follow the live fault condition
  always_ff @(posedge clk_i) begin
    if (srst) begin
      hp_short_q  <= 1'b0;
      spk_short_q <= 1'b0;
      otp_q       <= 1'b0;
    end else if (ce_i) begin
      hp_short_q  <= hp_l_short_i || hp_r_short_i;
      spk_short_q <= spk_short_i;
      otp_q       <= over_temp_i;
    end
  end

  // ----------------------------------------------------------------
  // soft-start ramp per output stage
  // ----------------------------------------------------------------
  assign pwr_now = {spk_drv_q[SPK_PWR_BIT], hp_drv_q[HP_R_PWR_BIT], hp_drv_q[HP_L_PWR_BIT]};

  always_ff @(posedge clk_i) begin
    if (srst) begin
      pwr_prev_q <= 3'h0;
    end else if (ce_i) begin
      pwr_prev_q <= pwr_now;
    end
  end

  generate
    for (genvar g = 0; g < 3; g++) begin : g_ramp
      logic [15:0] ramp_q;
      // any power edge restarts this stage's ramp only
      always_ff @(posedge clk_i) begin
        if (srst) begin
          ramp_q <= 16'h0000;
        end else if (ce_i) begin
          if (pwr_now[g] != pwr_prev_q[g]) begin
            ramp_q <= 16'(SOFTSTART_CYCLES);
          end else if (ramp_q != 16'h0000) begin
            ramp_q <= ramp_q - 16'h0001;
          end
        end
      end
      assign ramp_busy[g] = (ramp_q > 16'h0001) || (pwr_now[g] != pwr_prev_q[g]);
    end
  endgenerate

  // one process owns the busy flags, so each output bit has a single driver
  always_ff @(posedge clk_i) begin
    if (srst) begin
      stage_ramping_o <= 3'h0;
    end else if (ce_i) begin
      stage_ramping_o <= ramp_busy;
    end
  end

  // ----------------------------------------------------------------
  // speaker volume soft stepping
  // ----------------------------------------------------------------
  vol_softstep u_vol_l (
    .clk_i      (clk_i),
    .rst_i      (srst),
    .ce_i       (ce_i),
    .step_sel_i (softstep_q[1:0]),
    .target_i   (vol_l_q),
    .vol_o      (vol_l_s)
  );

  vol_softstep u_vol_r (
    .clk_i      (clk_i),
    .rst_i      (srst),
    .ce_i       (ce_i),
    .step_sel_i (softstep_q[1:0]),
    .target_i   (vol_r_q),
    .vol_o      (vol_r_s)
  );

  // ----------------------------------------------------------------
  // registered analog controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst) begin
      spk_vol_l_o              <= '{route: 1'b0, level: VOL_MUTE_CODE, mute: 1'b1};
      spk_vol_r_o              <= '{route: 1'b0, level: VOL_MUTE_CODE, mute: 1'b1};
      left_headphone_driver_o  <= '0;
      right_headphone_driver_o <= '0;
      speaker_driver_o         <= '0;
      hp_current_limit_o       <= 1'b1;
      hp_lineout_mode_o        <= 1'b0;
      hp_common_mode_o         <= 2'h0;
      speaker_switch_en_o      <= 1'b0;
    end else if (ce_i) begin
      spk_vol_l_o <= vol_l_s;
      spk_vol_r_o <= vol_r_s;
      left_headphone_driver_o  <= '{power: pwr_now[0], gain: hp_gain_l_q[6:3], mute: hp_gain_l_q[MUTE_BIT]};
      right_headphone_driver_o <= '{power: pwr_now[1], gain: hp_gain_r_q[6:3], mute: hp_gain_r_q[MUTE_BIT]};
      speaker_driver_o <= '{power: pwr_now[2], gain: {2'h0, spk_gain_q[4:3]}, mute: spk_gain_q[MUTE_BIT]};
      hp_current_limit_o  <= !hp_drv_q[HP_SHDN_BIT];
      hp_lineout_mode_o   <= (hp_mode_q[2:1] == HP_MODE_LINEOUT);
      hp_common_mode_o    <= hp_drv_q[4:3];
      speaker_switch_en_o <= pwr_now[2] && !over_temp_i;
    end
  end

  // ----------------------------------------------------------------
  // read mux; unmapped reads return zero
  // ----------------------------------------------------------------
  always_comb begin
    rd_d = 32'h0000_0000;
    case (idx)
      {1'b0, IDX_STATUS_P0}:    rd_d[OTP_FLAG_BIT] = otp_q;
      {1'b0, IDX_SOFTSTEP_P0}:  rd_d[7:0] = softstep_q;
      {1'b1, IDX_HP_DRV_P1}:    rd_d[7:0] = {hp_drv_q[7:1], hp_short_q};
      {1'b1, IDX_SPK_DRV_P1}:   rd_d[7:0] = {spk_drv_q[7:1], spk_short_q};
      {1'b1, IDX_SPK_VOL_L_P1}: rd_d[7:0] = vol_l_q;
      {1'b1, IDX_SPK_VOL_R_P1}: rd_d[7:0] = vol_r_q;
      {1'b1, IDX_HP_GAIN_L_P1}: rd_d[7:0] = hp_gain_l_q;
      {1'b1, IDX_HP_GAIN_R_P1}: rd_d[7:0] = hp_gain_r_q;
      {1'b1, IDX_SPK_GAIN_P1}:  rd_d[7:0] = spk_gain_q;
      {1'b1, IDX_HP_MODE_P1}:   rd_d[7:0] = hp_mode_q;
      default:                  rd_d[1]   = page1_q && (adr_i[9:2] == IDX_CONTROL);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (ce_i && rd_stb) begin
      dat_o <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_hp_trip_off: assert property (@(posedge clk_i) disable iff (srst)
    ce_i && hp_drv_q[1] && hp_l_short_i |=> !hp_drv_q[7])
    else $error("left headphone not shut down");
  a_hp_limit_on: assert property (@(posedge clk_i) disable iff (srst)
    ce_i && !hp_drv_q[1] && hp_drv_q[7] && !wr_hp |=> hp_drv_q[7])
    else $error("current limit mode dropped power");
  a_spk_trip_off: assert property (@(posedge clk_i) disable iff (srst)
    ce_i && spk_short_i |=> !spk_drv_q[7] && spk_short_q)
    else $error("speaker not shut down on overcurrent");
  a_hp_flag_set: assert property (@(posedge clk_i) disable iff (srst)
    ce_i && hp_r_short_i |=> hp_short_q)
    else $error("headphone short flag missing");
  a_otp_stop: assert property (@(posedge clk_i) disable iff (srst)
    ce_i && over_temp_i |=> !speaker_switch_en_o && otp_q)
    else $error("speaker switching during overtemp");
  a_spk_restart: assert property (@(posedge clk_i) disable iff (srst)
    ce_i && wr_spk && dat_i[7] && !spk_short_i |=> spk_drv_q[7] && hp_drv_q == $past(hp_drv_q))
    else $error("speaker re-enable failed or disturbed headphones");
  a_hp_restart: assert property (@(posedge clk_i) disable iff (srst)
    ce_i && wr_hp && dat_i[6] && !hp_r_short_i |=> hp_drv_q[6] && vol_l_q == $past(vol_l_q))
    else $error("headphone re-enable failed");
  a_shut_stays: assert property (@(posedge clk_i) disable iff (srst)
    ce_i && !spk_drv_q[7] && !wr_spk |=> !spk_drv_q[7])
    else $error("speaker came back without re-enable");
  a_softstart_run: assert property (@(posedge clk_i) disable iff (srst)
    ce_i && pwr_now[2] != pwr_prev_q[2] |=> stage_ramping_o[2])
    else $error("speaker soft start not flagged");
  a_lineout_sel: assert property (@(posedge clk_i) disable iff (srst)
    ce_i && hp_mode_q[2:1] == 2'h3 |=> hp_lineout_mode_o)
    else $error("line-output mode not applied");

  c_hp_trip:  cover property (@(posedge clk_i) hp_drv_q[7] ##1 !hp_drv_q[7]);
  c_spk_trip: cover property (@(posedge clk_i) spk_trip && spk_drv_q[7]);
  c_otp:      cover property (@(posedge clk_i) over_temp_i && spk_drv_q[7]);
  c_softrst:  cover property (@(posedge clk_i) soft_rst_q);

endmodule // output_stage_power_protect_ctrl

// file: tb/stage_fault_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// analog far side
// ----------------------------------------------------------------
// a shorted load only draws fault current while its stage drives,
// so a stage that was shut down stops reporting until it is re-enabled
module stage_fault_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] cmd_i,        // [0] hp left [1] hp right [2] speaker [3] heat
  input  wire logic       hp_l_pwr_i,
  input  wire logic       hp_r_pwr_i,
  input  wire logic       spk_pwr_i,
  output logic            hp_l_short_o = 1'b0,
  output logic            hp_r_short_o = 1'b0,
  output logic            spk_short_o  = 1'b0,
  output logic            over_temp_o  = 1'b0
);
  // detectors are registered, as the real comparators are
  always_ff @(posedge clk_i) begin
    hp_l_short_o <= cmd_i[0] & hp_l_pwr_i;
    hp_r_short_o <= cmd_i[1] & hp_r_pwr_i;
    spk_short_o  <= cmd_i[2] & spk_pwr_i;
    over_temp_o  <= cmd_i[3];
  end
endmodule // stage_fault_model

// file: tb/output_stage_power_protect_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module output_stage_power_protect_ctrl_tb;
  import out_stage_pkg::*;
  localparam int SS = 8;  // short soft start keeps the run brief
  // host clock plan for a 44.1 kHz stream; the block holds no divider itself
  localparam int converter_oversampling_ratio = 128;
  localparam int first_clock_divider          = 8;
  localparam int second_clock_divider         = 2;
  localparam int block_resource_count         = 6;  // plain default for the chosen processing block
  localparam int sample_hz                    = 44100;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat;
  logic        ack, climit, lineout, sw_en, hl_s, hr_s, sp_s, ot;
  logic [1:0]  cm;
  logic [2:0]  ramp;
  logic [3:0]  flt = 4'h0;
  logic        ce = 1'b1;
  vol_out_t    vol_l, vol_r;
  drv_out_t    hp_l, hp_r, spk;
  int          fail_count = 0;
  int          comparisons = 0;
  // ----------------------------------------------------------------
  // clock, design and far side
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  output_stage_power_protect_ctrl #(.SOFTSTART_CYCLES(SS)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .hp_l_short_i(hl_s), .hp_r_short_i(hr_s), .spk_short_i(sp_s), .over_temp_i(ot),
    .spk_vol_l_o(vol_l), .spk_vol_r_o(vol_r), .left_headphone_driver_o(hp_l),
    .right_headphone_driver_o(hp_r), .speaker_driver_o(spk), .hp_current_limit_o(climit),
    .hp_lineout_mode_o(lineout), .hp_common_mode_o(cm), .speaker_switch_en_o(sw_en),
    .stage_ramping_o(ramp));
  stage_fault_model fm (
    .clk_i(clk_i), .cmd_i(flt), .hp_l_pwr_i(hp_l.power), .hp_r_pwr_i(hp_r.power),
    .spk_pwr_i(spk.power), .hp_l_short_o(hl_s), .hp_r_short_o(hr_s),
    .spk_short_o(sp_s), .over_temp_o(ot));
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // classic cycle: hold everything until ack is sampled, then release
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'hf;
    adr <= {idx, 2'b00}; dat <= {24'h0, d};
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin fail_count++; $display("MISMATCH bus_ack exp 1 got %b", ack); end
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    `CHK(nm, {24'h0, e}, rdat)
  endtask
  // bounded wait for both volume levels to reach their targets
  task automatic settle(input logic [6:0] l, input logic [6:0] r);
    int n;
    n = 0;
    while ((vol_l.level !== l || vol_r.level !== r) && n < 5000) begin
      @(posedge clk_i); n++;
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // host clock plan must respect filter step, modulator rate and divider limits
    `CHK("osr_step", 1'b1, converter_oversampling_ratio % 8 == 0)
    `CHK("osr_rate", 1'b1, (converter_oversampling_ratio * sample_hz) inside {[2800001:6199999]})
    `CHK("div_range", 1'b1, first_clock_divider inside {[1:128]} && second_clock_divider inside {[1:128]})
    `CHK("div_res", 1'b1, second_clock_divider * converter_oversampling_ratio / 32 >= block_resource_count)
    bus(1'b1, IDX_CONTROL, 8'h02);
    rchk("vol_l_rst", IDX_SPK_VOL_L_P1, RST_VOL);
    rchk("hp_drv_rst", IDX_HP_DRV_P1, RST_ZERO);
    rchk("unmapped", 8'h7e, 8'h00);
    `CHK("climit_rst", 1'b1, climit)
    `CHK("vol_rst", {1'b0, 7'h7f, 1'b1}, vol_l)
    // fast stepping first, then code 0, the base step time
    bus(1'b1, IDX_CONTROL, 8'h00);
    bus(1'b1, IDX_SOFTSTEP_P0, 8'h03);
    rchk("step_sel", IDX_SOFTSTEP_P0, 8'h03);
    bus(1'b1, IDX_CONTROL, 8'h02);
    bus(1'b1, IDX_SPK_VOL_L_P1, 8'h92);
    bus(1'b1, IDX_SPK_VOL_R_P1, 8'h25);
    settle(7'h12, 7'h25);
    `CHK("vol_l", {1'b1, 7'h12, 1'b0}, vol_l)
    `CHK("vol_r", {1'b0, 7'h25, 1'b0}, vol_r)
    bus(1'b1, IDX_SPK_VOL_R_P1, 8'h7f);
    settle(7'h12, 7'h7f);
    `CHK("vol_r_mute", {1'b0, 7'h7f, 1'b1}, vol_r)
    bus(1'b1, IDX_CONTROL, 8'h00);
    bus(1'b1, IDX_SOFTSTEP_P0, 8'h00);
    bus(1'b1, IDX_CONTROL, 8'h02);
    bus(1'b1, IDX_SPK_VOL_L_P1, 8'h82);
    repeat (20) @(posedge clk_i);
    `CHK("vol_stepping", 1'b1, vol_l.level !== 7'h02)
    settle(7'h02, 7'h7f);
    `CHK("vol_stepped", {1'b1, 7'h02, 1'b0}, vol_l)
    // line-output drive mode, common mode and gains
    bus(1'b1, IDX_HP_MODE_P1, 8'h06);
    repeat (2) @(posedge clk_i);
    `CHK("lineout", 1'b1, lineout)
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, IDX_HP_DRV_P1, {3'b000, 2'(c), 3'b000});
      repeat (2) @(posedge clk_i);
      `CHK("common_mode", 2'(c), cm)
    end
    bus(1'b1, IDX_HP_GAIN_L_P1, 8'h54);
    bus(1'b1, IDX_HP_GAIN_R_P1, 8'h30);
    bus(1'b1, IDX_SPK_GAIN_P1, 8'h1c);
    repeat (2) @(posedge clk_i);
    `CHK("hp_l_gain", {4'ha, 1'b1}, {hp_l.gain, hp_l.mute})
    `CHK("hp_r_gain", {4'h6, 1'b0}, {hp_r.gain, hp_r.mute})
    `CHK("spk_gain", {4'h3, 1'b1}, {spk.gain, spk.mute})
    // power-up soft start on one stage only
    bus(1'b1, IDX_HP_DRV_P1, 8'h80);
    repeat (2) @(posedge clk_i);
    `CHK("ramp_busy", 3'b001, ramp)
    repeat (SS + 4) @(posedge clk_i);
    `CHK("ramp_done", 3'b000, ramp)
    `CHK("hp_l_on", 1'b1, hp_l.power)
    // current-limit mode keeps the stage up and flags the short
    flt <= 4'b0001;
    repeat (4) @(posedge clk_i);
    rchk("hp_limit", IDX_HP_DRV_P1, 8'h81);
    `CHK("hp_limit_pwr", 1'b1, hp_l.power)
    flt <= 4'b0000;
    // shutdown mode: trip, stay off, retry twice into a live fault
    bus(1'b1, IDX_HP_DRV_P1, 8'hc2);
    repeat (SS + 4) @(posedge clk_i);
    `CHK("climit_off", 1'b0, climit)
    flt <= 4'b0001;
    repeat (4) @(posedge clk_i);
    rchk("hp_trip", IDX_HP_DRV_P1, 8'h42);
    `CHK("hp_r_kept", 1'b1, hp_r.power)
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, IDX_HP_DRV_P1, 8'hc2);
      repeat (20) @(posedge clk_i);
      rchk("hp_retrip", IDX_HP_DRV_P1, 8'h42);
    end
    flt <= 4'b0000;
    bus(1'b1, IDX_HP_DRV_P1, 8'hc2);
    repeat (4) @(posedge clk_i);
    rchk("hp_restart", IDX_HP_DRV_P1, 8'hc2);
    flt <= 4'b0010;
    repeat (4) @(posedge clk_i);
    rchk("hp_r_trip", IDX_HP_DRV_P1, 8'h82);
    flt <= 4'b0000;
    // speaker: thermal stop and overcurrent shutdown
    bus(1'b1, IDX_SPK_DRV_P1, 8'h80);
    repeat (SS + 4) @(posedge clk_i);
    `CHK("spk_switch", 1'b1, sw_en)
    flt <= 4'b1000;
    repeat (4) @(posedge clk_i);
    `CHK("spk_hot", 1'b0, sw_en)
    bus(1'b1, IDX_CONTROL, 8'h00);
    rchk("otp_flag", IDX_STATUS_P0, 8'h02);
    flt <= 4'b0000;
    repeat (4) @(posedge clk_i);
    `CHK("spk_cool", 1'b1, sw_en)
    // clock enable low: an overheat must not reach the frozen outputs
    ce <= 1'b0;
    flt <= 4'b1000;
    repeat (4) @(posedge clk_i);
    `CHK("ce_freeze", 1'b1, sw_en)
    ce <= 1'b1;
    flt <= 4'b0000;
    repeat (4) @(posedge clk_i);
    bus(1'b1, IDX_CONTROL, 8'h02);
    flt <= 4'b0100;
    repeat (4) @(posedge clk_i);
    rchk("spk_trip", IDX_SPK_DRV_P1, 8'h00);
    `CHK("hp_l_kept", 1'b1, hp_l.power)
    flt <= 4'b0000;
    bus(1'b1, IDX_SPK_DRV_P1, 8'h80);
    repeat (4) @(posedge clk_i);
    rchk("spk_restart", IDX_SPK_DRV_P1, 8'h80);
    // software reset restores defaults, page select survives
    bus(1'b1, IDX_CONTROL, 8'h03);
    repeat (2) @(posedge clk_i);
    rchk("sw_rst_hp", IDX_HP_DRV_P1, RST_ZERO);
    rchk("sw_rst_vol", IDX_SPK_VOL_L_P1, RST_VOL);
    `CHK("sw_rst_pwr", 1'b0, hp_l.power)
    end_of_test();
  end
  // run needs about 3700 cycles; a hang is cut well beyond that
  initial begin
    #(20000 * 5);
    fail_count++;
    $display("MISMATCH watchdog exp done got hang");
    end_of_test();
  end
endmodule // output_stage_power_protect_ctrl_tb
